//--- shared/rld_pkg.sv
/*
  Shared constants for the re-leveling and door sequencer: register map,
  reset values, field positions and timing.
  Assumes a 125 MHz APB clock; positions are signed millimetres from floor.
*/
package rld_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;
  localparam int unsigned HOUR_MS      = 3_600_000;
  localparam int unsigned HOUR_W       = 22;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ZONE_UP   = 8'h04;
  localparam logic [7:0] OFS_ZONE_DN   = 8'h08;
  localparam logic [7:0] OFS_EXT_DN    = 8'h0C;
  localparam logic [7:0] OFS_LEVEL     = 8'h10;
  localparam logic [7:0] OFS_VEL       = 8'h14;
  localparam logic [7:0] OFS_ATTEMPTS  = 8'h18;
  localparam logic [7:0] OFS_TIMEOUT   = 8'h1C;
  localparam logic [7:0] OFS_DELAY     = 8'h20;
  localparam logic [7:0] OFS_DOOR_T    = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;
  localparam logic [7:0] OFS_FAULT     = 8'h2C;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_CLOSED   = 1;
  localparam int CTL_EXT      = 2;
  localparam int CTL_SEP      = 3;
  localparam int CTL_SEP_UP   = 4;
  localparam int CTL_SEP_DN   = 5;
  localparam int CTL_VN_OK    = 6;
  localparam int CTL_FIRE_LB  = 7;
  localparam int CTL_SWING    = 8;
  localparam int CTL_PRE_CAR  = 9;
  localparam int CTL_SW_OPEN  = 10;
  localparam int CTL_SW_CLOSE = 11;
  localparam int CTL_W        = 12;

  // fault register bits, write one to clear
  localparam int FLT_TIMEOUT  = 0;
  localparam int FLT_OPEN_SW  = 1;
  localparam int FLT_CLOSE_SW = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTL_W-1:0] RST_CTRL = 12'h071;
  localparam logic [14:0] RST_ZONE      = 15'h0032;
  localparam logic [14:0] RST_EXT       = 15'h0046;
  localparam logic [14:0] RST_LEVEL     = 15'h000A;
  localparam logic [8:0]  VEL_MAX_MMPS  = 9'h12C;
  localparam logic [8:0]  RST_VN_MMPS   = 9'h064;
  localparam logic [8:0]  RST_V0_MMPS   = 9'h064;
  localparam logic [4:0]  RST_ATTEMPTS  = 5'h06;
  localparam logic [15:0] RST_TIMEOUT   = 16'h3A98;
  localparam logic [15:0] RST_DELAY     = 16'h07D0;
  localparam logic [15:0] RST_DOOR_MS   = 16'h1770;

  typedef enum logic [1:0] {RL_IDLE, RL_DELAY, RL_RUN} rld_rl_state_t;
  typedef enum logic [2:0] {DR_IDLE, DR_OPENING, DR_OPENED, DR_CLOSING, DR_CLOSED}
    rld_door_state_t;
  typedef enum logic [2:0] {LK_IDLE, LK_WAIT_LANDING, LK_CLOSE_CAR, LK_LOCKED}
    rld_lock_state_t;

endpackage

//--- verilog/rld_relevel_door.sv
/*
  Re-leveling controller and basic door sequencer with an APB register file.
  Assumes all inputs synchronous to pclk, a single door, and that the drive,
  door machine and safety chain keep their own timing.
*/
//
// Behaviour
// - by default re-level with doors open, requesting the safety bridge module
// - closed-doors-only option: start re-leveling only with doors already closed
// - command re-leveling velocity, or creep velocity if drive lacks it
// - re-leveling velocity is clamped to at most 0.3 m/s
// - car outside the above/below re-leveling zone needs re-leveling
// - extended below limit applies when option set and doors closed
// - separate smaller level zone ends a run and is reported
// - global enable turns re-leveling on or off
// - separate unit drives up/down outputs, both, up only or down only
// - limit the number of re-leveling attempts per hour, for limits up to SLOTS (16)
// - cancel a run that exceeds the configured timeout
// - wait the configured delay after leaving the zone before starting
// - door without switches is done when its time span expires
// - door with switches missing its span logs a fault, stays operational
// - inspection/rescue: doors torque-free at rest, held closed when moving
// - emergency stop halts any door operation except the inspection/rescue hold-closed drive
// - swing doors: landing closed, then lock magnet, then close car door
// - car-door prerequisite: lock after car door closed, landing reopen reopens non-swing doors
// - lock magnet output is driven for every door type
// - on fire alarm the controller decides whether to honour light barrier
`timescale 1ns/1ps

module rld_relevel_door
  import rld_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = rld_pkg::MS_CYCLES,
  parameter int unsigned HOUR_TICKS  = rld_pkg::HOUR_MS,
  parameter int unsigned SLOTS       = 16
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] car_pos_mm,
  input  wire logic               car_moving,
  input  wire logic               car_start,
  input  wire logic               doors_closed,
  input  wire logic               landing_closed,
  input  wire logic               door_open_sw,
  input  wire logic               door_close_sw,
  input  wire logic               light_barrier,
  input  wire logic               fire_alarm,
  input  wire logic               inspection,
  input  wire logic               rescue,
  input  wire logic               emergency_stop,
  input  wire logic               door_open_cmd,
  input  wire logic               door_close_cmd,
  input  wire logic               start_req,
  output logic                    relevel_run,
  output logic                    relevel_dir_up,
  output logic [8:0]              relevel_velocity,
  output logic                    relevel_up,
  output logic                    relevel_down,
  output logic                    safety_bridge_module,
  output logic                    in_level_zone,
  output logic                    door_open_drive,
  output logic                    door_close_drive,
  output logic                    door_torque,
  output logic                    lock_magnet,
  output logic                    start_ok
);
  import rld_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [8:0] clamp_vel(input logic [8:0] v);
    clamp_vel = (v > VEL_MAX_MMPS) ? VEL_MAX_MMPS : v;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctrl;
  logic [14:0]      zone_up, zone_dn, ext_dn, level_zone;
  logic [8:0]       vn_mmps, v0_mmps;
  logic [4:0]       max_att;
  logic [15:0]      timeout_ms, delay_ms, open_ms, close_ms;
  logic             fault_to;
  logic [1:0]       fault_sw;
  logic             wr_en, rd_setup, hit;
  logic [31:0]      rd_val;

  rld_rl_state_t    rl_state;
  rld_door_state_t  dr_state;
  rld_lock_state_t  lk_state;
  logic [5:0]       active_cnt;

  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready   = 1'b1;

  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0;
    unique case (paddr)
      OFS_CTRL:     rd_val = {20'h0, ctrl};
      OFS_ZONE_UP:  rd_val = {17'h0, zone_up};
      OFS_ZONE_DN:  rd_val = {17'h0, zone_dn};
      OFS_EXT_DN:   rd_val = {17'h0, ext_dn};
      OFS_LEVEL:    rd_val = {17'h0, level_zone};
      OFS_VEL:      rd_val = {7'h0, v0_mmps, 7'h0, vn_mmps};
      OFS_ATTEMPTS: rd_val = {10'h0, active_cnt, 11'h0, max_att};
      OFS_TIMEOUT:  rd_val = {16'h0, timeout_ms};
      OFS_DELAY:    rd_val = {16'h0, delay_ms};
      OFS_DOOR_T:   rd_val = {close_ms, open_ms};
      OFS_STATUS:   rd_val = {21'h0, start_ok, lock_magnet, lk_state, dr_state,
                              in_level_zone, rl_state};
      OFS_FAULT:    rd_val = {29'h0, fault_sw, fault_to};
      default:      hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
      prdata <= rd_val;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl       <= RST_CTRL;
      zone_up    <= RST_ZONE;
      zone_dn    <= RST_ZONE;
      ext_dn     <= RST_EXT;
      level_zone <= RST_LEVEL;
      vn_mmps    <= RST_VN_MMPS;
      v0_mmps    <= RST_V0_MMPS;
      max_att    <= RST_ATTEMPTS;
      timeout_ms <= RST_TIMEOUT;
      delay_ms   <= RST_DELAY;
      open_ms    <= RST_DOOR_MS;
      close_ms   <= RST_DOOR_MS;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFS_CTRL:     ctrl       <= pwdata[CTL_W-1:0];
        OFS_ZONE_UP:  zone_up    <= pwdata[14:0];
        OFS_ZONE_DN:  zone_dn    <= pwdata[14:0];
        OFS_EXT_DN:   ext_dn     <= pwdata[14:0];
        OFS_LEVEL:    level_zone <= pwdata[14:0];
        OFS_VEL:
        begin
          vn_mmps <= clamp_vel(pwdata[8:0]);
          v0_mmps <= clamp_vel(pwdata[24:16]);
        end
        OFS_ATTEMPTS: max_att    <= pwdata[4:0];
        OFS_TIMEOUT:  timeout_ms <= pwdata[15:0];
        OFS_DELAY:    delay_ms   <= pwdata[15:0];
        OFS_DOOR_T:
        begin
          open_ms  <= pwdata[15:0];
          close_ms <= pwdata[31:16];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt;
  logic          ms_tick;

  assign ms_tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= '0;
    else
      tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // zone checks
  // ----------------------------------------------------------------
  logic signed [16:0] pos;
  logic [14:0]        dn_lim;
  logic               above_out, below_out, out_zone;

  assign pos       = {car_pos_mm[15], car_pos_mm};
  assign dn_lim    = (ctrl[CTL_EXT] && doors_closed) ? ext_dn : zone_dn;
  assign above_out = pos > $signed({2'b00, zone_up});
  assign below_out = pos < -$signed({2'b00, dn_lim});
  assign out_zone  = above_out | below_out;
  assign in_level_zone = (pos <= $signed({2'b00, level_zone})) &&
                         (pos >= -$signed({2'b00, level_zone}));

  // ----------------------------------------------------------------
  // attempts in the last hour, one countdown per attempt
  // ----------------------------------------------------------------
  logic [HOUR_W-1:0] slot_left [SLOTS];
  logic [SLOTS-1:0]  slot_busy;
  logic [$clog2(SLOTS)-1:0] free_idx;
  logic              attempt, att_ok;

  always_comb
  begin
    free_idx   = '0;
    active_cnt = '0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (!slot_busy[i])
        free_idx = ($clog2(SLOTS))'(i);
      active_cnt = active_cnt + {5'h0, slot_busy[i]};
    end
  end

  assign att_ok = active_cnt < {1'b0, max_att};

  for (genvar g = 0; g < SLOTS; g++)
  begin : g_slot
    assign slot_busy[g] = slot_left[g] != '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        slot_left[g] <= '0;
      else if (attempt && free_idx == ($clog2(SLOTS))'(g) && !slot_busy[g])
        slot_left[g] <= HOUR_W'(HOUR_TICKS);
      else if (ms_tick && slot_busy[g])
        slot_left[g] <= slot_left[g] - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // re-leveling sequencer
  // ----------------------------------------------------------------
  logic [15:0] rl_ms;
  logic        may_start, timed_out, go_up;

  // closed-only mode never needs the bridge, so it waits for shut doors
  assign may_start = ctrl[CTL_ENABLE] && !car_moving && att_ok &&
                     (!ctrl[CTL_CLOSED] || doors_closed);
  assign timed_out = (rl_state == RL_RUN) && (rl_ms >= timeout_ms);
  assign attempt   = (rl_state == RL_DELAY) && ms_tick && (rl_ms >= delay_ms) &&
                     out_zone && may_start;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rl_state <= RL_IDLE;
      rl_ms    <= '0;
      go_up    <= 1'b0;
    end
    else
    begin
      unique case (rl_state)
        RL_IDLE:
          if (may_start && out_zone)
          begin
            rl_state <= RL_DELAY;
            rl_ms    <= '0;
          end
        RL_DELAY:
          if (!out_zone || !may_start)
            rl_state <= RL_IDLE;                           // sway filtered
          else if (attempt)
          begin
            rl_state <= RL_RUN;
            rl_ms    <= '0;
            go_up    <= below_out;
          end
          else if (ms_tick)
            rl_ms <= rl_ms + 1'b1;
        RL_RUN:
          if (timed_out || !ctrl[CTL_ENABLE] || in_level_zone)
            rl_state <= RL_IDLE;
          else if (ms_tick)
            rl_ms <= rl_ms + 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_to <= 1'b0;
    else if (timed_out)
      fault_to <= 1'b1;                                    // set beats clear
    else if (wr_en && paddr == OFS_FAULT && pwdata[FLT_TIMEOUT])
      fault_to <= 1'b0;
  end

  logic running, use_sep;
  assign running = (rl_state == RL_RUN) && !timed_out;
  assign use_sep = ctrl[CTL_SEP] &&
                   (go_up ? ctrl[CTL_SEP_UP] : ctrl[CTL_SEP_DN]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relevel_run          <= 1'b0;
      relevel_dir_up       <= 1'b0;
      relevel_velocity     <= '0;
      relevel_up           <= 1'b0;
      relevel_down         <= 1'b0;
      safety_bridge_module <= 1'b0;
    end
    else
    begin
      relevel_run          <= running && !use_sep;
      relevel_dir_up       <= go_up;
      relevel_velocity     <= running ? (ctrl[CTL_VN_OK] ? vn_mmps : v0_mmps) : '0;
      relevel_up           <= running && use_sep && go_up;
      relevel_down         <= running && use_sep && !go_up;
      safety_bridge_module <= running && !ctrl[CTL_CLOSED] && !doors_closed;
    end
  end

  // ----------------------------------------------------------------
  // door machine
  // ----------------------------------------------------------------
  logic [15:0] dr_ms;
  logic        lb_eff, special, req_open, req_close, open_done, close_done;

  // smoke can trip the barrier, so fire mode follows the control bit
  assign lb_eff  = light_barrier && (!fire_alarm || ctrl[CTL_FIRE_LB]);
  assign special = inspection || rescue;
  assign open_done  = ctrl[CTL_SW_OPEN] ? door_open_sw : (dr_ms >= open_ms);
  assign close_done = ctrl[CTL_SW_CLOSE] ? door_close_sw : (dr_ms >= close_ms);
  assign req_open  = door_open_cmd || (lk_state == LK_CLOSE_CAR && !landing_closed);
  assign req_close = door_close_cmd || lk_state == LK_CLOSE_CAR || lk_state == LK_LOCKED;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dr_state <= DR_IDLE;
      dr_ms    <= '0;
    end
    else if (emergency_stop || (special && !car_moving && !car_start))
    begin
      dr_state <= DR_IDLE;
      dr_ms    <= '0;
    end
    else
    begin
      if (ms_tick && dr_ms != 16'hFFFF)
        dr_ms <= dr_ms + 1'b1;
      unique case (dr_state)
        DR_IDLE, DR_CLOSED, DR_OPENED:
          if (req_open && dr_state != DR_OPENED && !special)
          begin
            dr_state <= DR_OPENING;
            dr_ms    <= '0;
          end
          else if ((req_close || (special && car_moving)) && dr_state != DR_CLOSED)
          begin
            dr_state <= DR_CLOSING;
            dr_ms    <= '0;
          end
        DR_OPENING:
          if (open_done || dr_ms >= open_ms)
            dr_state <= DR_OPENED;                         // operational anyway
        DR_CLOSING:
          if ((lb_eff || req_open) && !special)
          begin
            dr_state <= DR_OPENING;
            dr_ms    <= '0;
          end
          else if (close_done || dr_ms >= close_ms)
            dr_state <= DR_CLOSED;
      endcase
    end
  end

  logic open_miss, close_miss;
  assign open_miss  = dr_state == DR_OPENING && ctrl[CTL_SW_OPEN] &&
                      !door_open_sw && dr_ms >= open_ms;
  assign close_miss = dr_state == DR_CLOSING && ctrl[CTL_SW_CLOSE] &&
                      !door_close_sw && !lb_eff && dr_ms >= close_ms;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_sw <= 2'b00;
    else
    begin
      if (open_miss)
        fault_sw[0] <= 1'b1;
      else if (wr_en && paddr == OFS_FAULT && pwdata[FLT_OPEN_SW])
        fault_sw[0] <= 1'b0;
      if (close_miss)
        fault_sw[1] <= 1'b1;
      else if (wr_en && paddr == OFS_FAULT && pwdata[FLT_CLOSE_SW])
        fault_sw[1] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      door_open_drive  <= 1'b0;
      door_close_drive <= 1'b0;
      door_torque      <= 1'b0;
    end
    else
    begin
      door_open_drive  <= dr_state == DR_OPENING;
      door_close_drive <= dr_state == DR_CLOSING ||
                          (special && (car_moving || car_start));
      door_torque      <= (dr_state == DR_OPENING || dr_state == DR_CLOSING) ||
                          (special && (car_moving || car_start));
    end
  end

  // ----------------------------------------------------------------
  // landing lock sequence before a start
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lk_state <= LK_IDLE;
    else if (emergency_stop || !start_req)
      lk_state <= LK_IDLE;
    else
    begin
      unique case (lk_state)
        LK_IDLE:
          lk_state <= (ctrl[CTL_SWING] && !ctrl[CTL_PRE_CAR]) ?
                      LK_WAIT_LANDING : LK_CLOSE_CAR;
        LK_WAIT_LANDING:
          if (landing_closed)
            lk_state <= LK_LOCKED;                          // magnet before car door
        LK_CLOSE_CAR:
          if (doors_closed && landing_closed && dr_state == DR_CLOSED)
            lk_state <= LK_LOCKED;
        LK_LOCKED:
          if (!landing_closed && !ctrl[CTL_SWING])
            lk_state <= LK_CLOSE_CAR;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_magnet <= 1'b0;
      start_ok    <= 1'b0;
    end
    else
    begin
      lock_magnet <= lk_state == LK_LOCKED;
      start_ok    <= lk_state == LK_LOCKED && doors_closed && dr_state == DR_CLOSED;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_timeout;
    rl_state == RL_RUN && rl_ms >= timeout_ms;
  endsequence

  a_vel_limit: assert property (relevel_velocity <= VEL_MAX_MMPS)
    else $error("re-leveling velocity above limit");
  a_closed_only: assert property ((ctrl[CTL_CLOSED] && !doors_closed) |-> !attempt)
    else $error("run started with doors open in closed-only mode");
  a_timeout_stop: assert property (s_timeout |=> !relevel_run && !relevel_up &&
                                   !relevel_down && fault_to)
    else $error("timeout did not stop re-leveling");
  a_att_limit: assert property (attempt |-> active_cnt < {1'b0, max_att})
    else $error("attempt started above hourly limit");
  a_delay_wait: assert property ($rose(rl_state == RL_RUN) |-> $past(rl_ms) >= delay_ms)
    else $error("run started before delay");
  a_disable: assert property (!ctrl[CTL_ENABLE] |=> rl_state != RL_RUN && !attempt)
    else $error("re-leveling while disabled");
  a_estop_door: assert property (emergency_stop |=> dr_state == DR_IDLE)
    else $error("door kept moving after emergency stop");
  a_insp_hold: assert property ((special && car_moving) |=> door_close_drive && door_torque)
    else $error("door not held closed while moving");
  a_sep_out: assert property ((relevel_up || relevel_down) |-> $past(ctrl[CTL_SEP]))
    else $error("separate unit output without the unit");
  a_lock_order: assert property ($rose(lock_magnet) |-> $past(landing_closed, 2))
    else $error("lock magnet energised with landing door open");

endmodule // rld_relevel_door

//--- tb/rld_far_side.sv
/*
  Far-side model: a car that moves 1 mm per clock while a run is commanded.
  Assumes the bench loads the start position and may stall the car.
*/
`timescale 1ns/1ps
module rld_far_side (
  input  wire logic               pclk,
  input  wire logic               load,
  input  wire logic signed [15:0] load_pos,
  input  wire logic               stall,
  input  wire logic               relevel_run,
  input  wire logic               relevel_dir_up,
  output logic signed [15:0]      car_pos_mm
);
  // a stalled car keeps its place, so only the timeout or clearing the enable bit can end the run
  always_ff @(posedge pclk)
  begin
    if (load)
      car_pos_mm <= load_pos;
    else if (relevel_run && !stall)
      car_pos_mm <= relevel_dir_up ? car_pos_mm + 16'sd1 : car_pos_mm - 16'sd1;
  end
endmodule // rld_far_side

//--- tb/tb.sv
/*
  Self-checking bench for the re-leveling and door sequencer.
  Assumes a 1 ms tick of 10 clocks and a short hour.
*/
`timescale 1ns/1ps
module tb;
  import rld_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 1, stall = 0;
  logic [7:0] paddr = 8'h00, rnd = 8'h63;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, serr, run, up, bridge, inlz, odrv, estop = 0, ocmd = 0;
  logic signed [15:0] pos, lpos = 16'sh0000;
  logic [8:0] vel;
  logic z = 0, dcl = 0, lcl = 0, sreq = 0;
  int err_total = 0, checked = 0, cyc = 0, i;
  always #4 pclk = ~pclk;
  rld_far_side car (.pclk(pclk), .load(load), .load_pos(lpos), .stall(stall),
    .relevel_run(run), .relevel_dir_up(up), .car_pos_mm(pos));
  rld_relevel_door #(.TICK_CYCLES(10), .HOUR_TICKS(200)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .car_pos_mm(pos), .car_moving(z), .car_start(z), .doors_closed(dcl),
    .landing_closed(lcl), .door_open_sw(z), .door_close_sw(z), .light_barrier(z),
    .fire_alarm(z), .inspection(z), .rescue(z), .emergency_stop(estop),
    .door_open_cmd(ocmd), .door_close_cmd(z), .start_req(sreq), .relevel_run(run),
    .relevel_dir_up(up), .relevel_velocity(vel), .relevel_up(), .relevel_down(),
    .safety_bridge_module(bridge), .in_level_zone(inlz), .door_open_drive(odrv),
    .door_close_drive(), .door_torque(), .lock_magnet(), .start_ok());
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitrun(input logic lvl);
    for (i = 0; i < 600 && run !== lvl; i++) @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    ap(0, OFS_CTRL, 0); cmp(q, 32'(RST_CTRL));
    ap(1, OFS_VEL, 32'h01FF_01FF); ap(0, OFS_VEL, 0); cmp(q, 32'h012C_012C);
    ap(0, 8'h40, 0); cmp({serr, q[30:0]}, 32'h8000_0000);
    ap(1, OFS_VEL, 32'h0050_0050); ap(1, OFS_DELAY, 32'h5); ap(1, OFS_TIMEOUT, 32'h14);
    ap(1, OFS_DOOR_T, 32'h0003_0003);
    // ----------------------------------------------------------------
    // random sink below the zone, delayed start, run back to level
    // ----------------------------------------------------------------
    repeat (2)
    begin
      rnd = lfsr(rnd);
      lpos <= -16'sd51 - 16'(rnd % 20);
      load <= 1'b1; @(posedge pclk); load <= 1'b0;
      repeat (40) @(posedge pclk); cmp(run, 0);
      waitrun(1); cmp({run, up, bridge, vel}, {3'b111, 9'd80});
      waitrun(0); cmp({inlz, vel}, {1'b1, 9'd0});
    end
    stall <= 1'b1;
    lpos <= -16'sd60;
    load <= 1'b1; @(posedge pclk); load <= 1'b0;
    waitrun(1); waitrun(0); lpos <= 16'sh0000; load <= 1'b1; stall <= 1'b0;
    cmp(vel, 0); ap(0, OFS_FAULT, 0); cmp(q[0], 1);
    // ----------------------------------------------------------------
    // closed-only, extended zone, hourly limit, global enable
    // ----------------------------------------------------------------
    ap(1, OFS_CTRL, 32'h077); lpos <= -16'sd60;
    repeat (150) @(posedge pclk); cmp(run, 0);
    dcl <= 1'b1; repeat (150) @(posedge pclk); cmp(run, 0);
    load <= 1'b0; ap(1, OFS_CTRL, 32'h073);
    waitrun(1); cmp({run, bridge}, 2'b10);
    waitrun(0); ap(0, OFS_ATTEMPTS, 0); cmp(q[21:16], 4);
    ap(1, OFS_ATTEMPTS, 32'h4); lpos <= -16'sd60; load <= 1'b1;
    repeat (150) @(posedge pclk); cmp(run, 0);
    ap(1, OFS_ATTEMPTS, 32'h6); ap(1, OFS_CTRL, 32'h070); load <= 1'b0;
    repeat (150) @(posedge pclk); cmp(run, 0);
    // ----------------------------------------------------------------
    // door span, emergency stop, landing lock
    // ----------------------------------------------------------------
    ocmd <= 1'b1; repeat (5) @(posedge pclk); cmp(odrv, 1);
    estop <= 1'b1; repeat (3) @(posedge pclk); cmp(odrv, 0);
    estop <= 1'b0; repeat (50) @(posedge pclk); ap(0, OFS_STATUS, 0); cmp(q[5:3], 2);
    {ocmd, lcl, sreq} <= 3'b011; repeat (60) @(posedge pclk);
    ap(0, OFS_STATUS, 0); cmp(q[10:9], 2'b11);
    end_of_test();
  end
endmodule // tb
